// ### bench/acsi_props.sv
// Checker for the serial link between the converter and host ends.
`timescale 1ns/100ps
`default_nettype none
module acsi_props (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic csN,
    input wire logic sdi,
    input wire logic sdoOeN,
    input wire logic sckDevOeN,
    input wire logic busy,
    input wire logic clockSourceSelectN,
    input wire logic sck,
    input wire logic sdoLine
);
    logic       sckPrev_q;
    logic [5:0] riseCnt_q;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    // Counts serial clock rising edges within the current frame.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sckPrev_q <= 1'b0;
            riseCnt_q <= 6'h00;
        end
        else
        begin
            sckPrev_q <= sck;
            if (csN)
                riseCnt_q <= 6'h00;
            else if (sck && !sckPrev_q)
                riseCnt_q <= riseCnt_q + 6'h01;
        end
    end
    chk_sdo_released: assert property (csN |-> sdoOeN)
        else $error("sdo driven while deselected");
    chk_sdo_enabled: assert property (!csN |-> !sdoOeN)
        else $error("sdo not driven while selected");
    chk_dev_clock: assert property (!sckDevOeN |-> clockSourceSelectN)
        else $error("device drives clock in host clock mode");
    chk_host_clock: assert property (!clockSourceSelectN |-> sckDevOeN)
        else $error("clock pin not released in host clock mode");
    chk_sleep_hold: assert property ((!busy && csN && $past(csN)) |=> !busy)
        else $error("sleep left while deselected");
    chk_status_conv: assert property ((!csN && busy && $past(busy)) |-> sdoLine)
        else $error("status low during conversion");
    chk_frame_end: assert property ($rose(busy) |-> !$past(csN) && riseCnt_q == 6'h20)
        else $error("conversion started before 32 bits");
    chk_busy_output: assert property ($fell(csN) |-> !busy ##1 !busy [*8])
        else $error("busy high during data output");
    chk_data_fall: assert property ((!csN && sck && $past(sck)) |-> $stable(sdoLine))
        else $error("sdo changed while clock high");
    chk_cfg_rise: assert property ((!csN && $rose(sck)) |-> $stable(sdi))
        else $error("sdi changed at clock rise");
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Bench joining host and converter ends, plus a bench-driven second converter.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int TMO = 40000;
    // One conversion clock edge every two cycles; ratio code 0 is 128.
    localparam int CONV_CYC = 2 * (acsi_pkg::CONV_K * 128 + acsi_pkg::CONV_OFS);
    localparam logic [8:0] SEL_RST = {4'h0, 4'h1, 1'b0};
    logic        sys_clk, rstn, convClockExt, twoXSel, twoXSelB;
    logic [24:0] sampleIn, sampleInB;
    logic [3:0]  channelSel, osrSel, channelSelB, osrSelB, wstrb;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, word;
    logic [1:0]  bresp, rresp, resp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    int          errorCnt, cmpCount, n;
    wire logic [8:0] selA = {channelSel, osrSel, twoXSel};
    acsi_link_if link ();
    acsi_link_if linkB ();
    acsi_host i_acsi_host (.sys_clk, .rstn, .link(link), .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready);
    acsi_device i_acsi_device (.sys_clk, .rstn, .link(link), .convClockControlTied(1'b0),
        .convClockExt, .sampleIn, .channelSel, .osrSel, .twoXSel);
    acsi_device i_acsi_device_b (.sys_clk, .rstn, .link(linkB),
        .convClockControlTied(1'b0), .convClockExt, .sampleIn(sampleInB),
        .channelSel(channelSelB), .osrSel(osrSelB), .twoXSel(twoXSelB));
    acsi_props i_acsi_props (.sys_clk, .rstn, .csN(link.csN), .sdi(link.sdi),
        .sdoOeN(link.sdoOeN), .sckDevOeN(link.sckDevOeN), .busy(link.busy),
        .clockSourceSelectN(link.clockSourceSelectN), .sck(link.sck),
        .sdoLine(link.sdoLine));
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) convClockExt <= ~convClockExt;
    task automatic checkData(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stopTest();
        $display("Counts: compares=%0d mismatches=%0d", cmpCount, errorCnt);
        if (errorCnt == 0 && cmpCount > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic bounded(input int k);
        if (k >= TMO)
        begin
            errorCnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, k, TMO);
            stopTest();
        end
    endtask
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        k = 0;
        do
        begin
            @(posedge sys_clk);
            k++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (!bvalid && k < TMO);
        resp = bresp;
        bready <= 1'b0;
        bounded(k);
    endtask
    task automatic axiRead(input logic [7:0] a);
        int k;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        k = 0;
        do
        begin
            @(posedge sys_clk);
            k++;
            if (arready)
                arvalid <= 1'b0;
        end while (!rvalid && k < TMO);
        word = rdata;
        resp = rresp;
        rready <= 1'b0;
        bounded(k);
    endtask
    task automatic waitBusy(input logic b, input logic want);
        n = 0;
        while ((b ? linkB.busy : link.busy) !== want && n < TMO)
        begin
            @(posedge sys_clk);
            n++;
        end
        bounded(n);
    endtask
    task automatic pulseB(input int cnt);
        repeat (cnt)
        begin
            repeat (acsi_pkg::SCK_HALF) @(posedge sys_clk);
            linkB.sckHost <= 1'b1;
            repeat (acsi_pkg::SCK_HALF) @(posedge sys_clk);
            linkB.sckHost <= 1'b0;
        end
    endtask
    // Waits out a frame and the conversion after it, then checks what the host captured.
    task automatic frame(input logic [24:0] s, input logic [8:0] sel);
        waitBusy(1'b0, 1'b1);
        waitBusy(1'b0, 1'b0);
        checkData(32'(n >= CONV_CYC - 4 && n <= CONV_CYC + 8), 32'h1);
        axiRead(acsi_pkg::ADDR_RESULT);
        checkData(word, {2'b00, s, 5'h00});
        axiRead(acsi_pkg::ADDR_STAT);
        checkData(word, 32'h0000_0004);
        checkData(32'(selA), 32'(sel));
    endtask
    initial
    begin
        rstn = 1'b0;
        convClockExt = 1'b0;
        sampleIn = 25'h1A55A5C;
        sampleInB = 25'h0F0F0F0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        linkB.csN = 1'b0;
        linkB.sdi = 1'b1;
        linkB.sckHost = 1'b0;
        linkB.sckHostOeN = 1'b0;
        linkB.clockSourceSelectN = 1'b0;
        errorCnt = 0;
        cmpCount = 0;
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        axiRead(acsi_pkg::ADDR_STAT);
        checkData(word, 32'h0000_0006);
        checkData(32'(selA), 32'(SEL_RST));
        axiRead(8'h10);
        checkData({word[29:0], resp}, 32'h0000_0002);
        axiWrite(8'h10, 32'h0000_FFFF);
        checkData(32'(resp), 32'h0000_0002);
        checkData(32'(linkB.sdoOeN), 32'h0);
        checkData(32'(linkB.sdoLine), 32'h1);
        $display("reset test done");
        waitBusy(1'b1, 1'b0);
        @(posedge sys_clk);
        checkData(32'(linkB.sdoLine), 32'h0);
        pulseB(10);
        @(posedge sys_clk);
        linkB.csN <= 1'b1;
        waitBusy(1'b1, 1'b1);
        checkData(32'(n <= 6), 32'h1);
        checkData(32'(linkB.sdoOeN), 32'h1);
        checkData(32'({channelSelB, osrSelB, twoXSelB}), 32'(SEL_RST));
        $display("abort test done");
        waitBusy(1'b0, 1'b0);
        sampleIn <= 25'h0123456;
        axiWrite(acsi_pkg::ADDR_CFG, 32'h0000_80C0);
        axiWrite(acsi_pkg::ADDR_CTRL, 32'h0000_0001);
        frame(25'h1A55A5C, 9'h060);
        $display("host clock test done");
        axiWrite(acsi_pkg::ADDR_CFG, 32'h0000_7C40);
        axiWrite(acsi_pkg::ADDR_CTRL, 32'h0000_0003);
        frame(25'h0123456, 9'h060);
        $display("device clock test done");
        stopTest();
    end
endmodule
`default_nettype wire

// ### rtl/acsi_device.sv
// Converter end: conversion cycle, status pins and serial shifter.
// Notes on behaviour
// - Internal mode drives clock pin, external samples it.
// - Select low: host clock; high: device clock.
// - Busy high converting, low sleep and output.
// - Serial input carries next conversion selection.
// - Reset defaults: first channel, ratio 256, 1X.
// - Enable bit low keeps previous selection.
// - First conversion after new selection valid.
// - Tied control pin selects internal oscillator.
// - Conversion time from 40*ratio+170 clocks.
// - External conversion clock at most 10.24MHz.
// - Chip select low enables output, wakes.
// - Sleep after conversion while select high.
// - Select rising during output aborts, converts.
// - Output high impedance while select high.
// - Status on output: high converting, low done.
// - Cycle conversion, sleep, output, conversion.
// - Result held unchanged in sleep.
// - 1X output is just finished conversion.
// - Output changes on falling clock edge.
// - Output ends after 32 bits or deselect.
// - Word: flag, dummy, sign, 24 bits, 5 sub.
// - Output high after 32nd falling edge.
`timescale 1ns/100ps
`default_nettype none
module acsi_device (
    input  wire logic                        sys_clk,
    input  wire logic                        rstn,
    acsi_link_if.device                      link,
    input  wire logic                        convClockControlTied,
    input  wire logic                        convClockExt,
    input  wire logic [acsi_pkg::DATA_W:0]   sampleIn,
    output logic [acsi_pkg::CFG_CH_W-1:0]    channelSel,
    output logic [acsi_pkg::CFG_OSR_W-1:0]   osrSel,
    output logic                             twoXSel
);
    acsi_pkg::acsi_state_t state_q;
    logic [31:0] convCnt_q;
    logic [31:0] convLen;
    logic [31:0] shift_q;
    logic [5:0]  bitCnt_q;
    logic [acsi_pkg::CFG_W-1:0] cfgShift_q;
    logic [acsi_pkg::CFG_CH_W-1:0]  ch_q;
    logic [acsi_pkg::CFG_OSR_W-1:0] osr_q;
    logic twoX_q;
    logic csPrev_q;
    logic sckPrev_q;
    logic extPrev_q;
    logic convTick;
    logic intTick;
    logic sckGen_q;
    logic sckTick;
    logic useDevClk;
    logic sckNow;
    logic sckRise;
    logic sckFall;
    logic frameDone;
    logic abort;
    logic convDone;
    logic doneFlag_q;

    assign useDevClk = link.clockSourceSelectN;
    assign sckNow = useDevClk ? sckGen_q : link.sck;
    assign sckRise = sckNow && !sckPrev_q;
    assign sckFall = !sckNow && sckPrev_q;
    assign abort = state_q == acsi_pkg::ST_XFER && link.csN && !csPrev_q;
    assign frameDone = state_q == acsi_pkg::ST_XFER && sckFall && bitCnt_q == 6'd31;
    // Ratio is 2^((code+7) mod 16), as the sum is 4 bits wide, so code 1 gives 256.
    assign convLen = 32'(acsi_pkg::CONV_K) * (32'h1 << (osr_q + 4'd7)) + 32'(acsi_pkg::CONV_OFS);
    assign convDone = state_q == acsi_pkg::ST_CONV && convTick && convCnt_q + 32'h1 >= convLen;

    acsi_divider #(.DIV(acsi_pkg::CONV_CLK_DIV)) uConvDiv (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .run     (1'b1),
        .tick    (intTick)
    );
    acsi_divider #(.DIV(acsi_pkg::SCK_HALF)) uSckDiv (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .run     (state_q == acsi_pkg::ST_XFER && useDevClk),
        .tick    (sckTick)
    );

    // External clock rising edge counts; nothing here keeps it below 10.24MHz.
    assign convTick = convClockControlTied ? intTick : (convClockExt && !extPrev_q);

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            csPrev_q <= 1'b1;
            sckPrev_q <= 1'b0;
            extPrev_q <= 1'b0;
        end
        else
        begin
            csPrev_q <= link.csN;
            sckPrev_q <= sckNow;
            extPrev_q <= convClockExt;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            state_q <= acsi_pkg::ST_CONV;
        else
        begin
            unique case (state_q)
                acsi_pkg::ST_CONV:  if (convDone) state_q <= acsi_pkg::ST_SLEEP;
                acsi_pkg::ST_SLEEP: if (!link.csN) state_q <= acsi_pkg::ST_XFER;
                acsi_pkg::ST_XFER:  if (abort || frameDone) state_q <= acsi_pkg::ST_CONV;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            convCnt_q <= 32'h0;
        else if (state_q != acsi_pkg::ST_CONV)
            convCnt_q <= 32'h0;
        else if (convTick)
            convCnt_q <= convCnt_q + 32'h1;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            sckGen_q <= 1'b0;
        else if (state_q != acsi_pkg::ST_XFER)
            // Idles low so the first edge seen in a frame is a rise, as with the host clock.
            sckGen_q <= 1'b0;
        else if (sckTick)
            sckGen_q <= !sckGen_q;
    end

    // Result loads once at conversion end and only shifts in output.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            shift_q <= 32'h0;
            bitCnt_q <= 6'd0;
            doneFlag_q <= 1'b0;
        end
        else if (convDone)
        begin
            shift_q <= {1'b0, 1'b0, sampleIn, 5'h00};
            bitCnt_q <= 6'd0;
            doneFlag_q <= 1'b1;
        end
        else if (state_q == acsi_pkg::ST_XFER && sckFall && !link.csN)
        begin
            shift_q <= {shift_q[30:0], 1'b1};
            bitCnt_q <= bitCnt_q + 6'd1;
        end
        else if (state_q == acsi_pkg::ST_CONV)
            doneFlag_q <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            cfgShift_q <= '0;
        else if (state_q == acsi_pkg::ST_SLEEP)
            cfgShift_q <= '0;
        // Only the first word of the frame is kept; later bits would push it out.
        else if (state_q == acsi_pkg::ST_XFER && sckRise && !link.csN
                 && bitCnt_q < 6'(acsi_pkg::CFG_W))
            cfgShift_q <= {cfgShift_q[acsi_pkg::CFG_W-2:0], link.sdi};
    end

    // Selection is applied at frame end only when the enable bit is set.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ch_q <= acsi_pkg::CH_CODE_RESET;
            osr_q <= acsi_pkg::OSR_CODE_RESET;
            twoX_q <= acsi_pkg::TWOX_RESET;
        end
        else if (frameDone && cfgShift_q[acsi_pkg::CFG_ENABLE_POS])
        begin
            ch_q <= cfgShift_q[acsi_pkg::CFG_CH_POS +: acsi_pkg::CFG_CH_W];
            osr_q <= cfgShift_q[acsi_pkg::CFG_OSR_POS +: acsi_pkg::CFG_OSR_W];
            twoX_q <= cfgShift_q[acsi_pkg::CFG_TWOX_POS];
        end
    end

    assign channelSel = ch_q;
    assign osrSel = osr_q;
    assign twoXSel = twoX_q;
    assign link.busy = state_q == acsi_pkg::ST_CONV;
    assign link.sdoOeN = link.csN;
    assign link.sdo = state_q == acsi_pkg::ST_XFER ? shift_q[31]
                    : (!doneFlag_q || state_q == acsi_pkg::ST_CONV);
    assign link.sckDev = sckGen_q;
    assign link.sckDevOeN = !(useDevClk && state_q == acsi_pkg::ST_XFER);
endmodule
`default_nettype wire

// ### rtl/acsi_divider.sv
// Enable pulse divider for the conversion and serial clocks.
`timescale 1ns/100ps
`default_nettype none
module acsi_divider #(
    parameter int DIV = 2
) (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic run,
    output logic      tick
);
    logic [15:0] cnt_q;
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            cnt_q <= 16'h0000;
        else if (!run || cnt_q == 16'(DIV - 1))
            cnt_q <= 16'h0000;
        else
            cnt_q <= cnt_q + 16'h0001;
    end
    assign tick = run && (cnt_q == 16'(DIV - 1));
endmodule
`default_nettype wire

// ### rtl/acsi_host.sv
// Host end: AXI4-Lite slave that runs serial frames to the converter.
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module acsi_host (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    acsi_link_if.host        link,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);
    logic [acsi_pkg::CFG_W-1:0] cfg_q;
    logic devClk_q;
    logic start_q;
    logic active_q;
    logic [31:0] rx_q;
    logic [31:0] result_q;
    logic [acsi_pkg::CFG_W-1:0] tx_q;
    logic [5:0] cnt_q;
    logic sck_q;
    logic sckPrev_q;
    logic [3:0] div_q;
    logic awHave_q;
    logic wHave_q;
    logic [7:0] awA_q;
    logic [31:0] wD_q;
    logic busyPrev_q;
    logic rise;
    logic fall;

    assign rise = link.sck && !sckPrev_q;
    assign fall = !link.sck && sckPrev_q;
    assign awready = !awHave_q && !bvalid;
    assign wready = !wHave_q && !bvalid;
    assign arready = !rvalid;

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awA_q <= 8'h00;
            wD_q <= 32'h0;
            bvalid <= 1'b0;
            bresp <= 2'b00;
            cfg_q <= '0;
            devClk_q <= 1'b0;
            start_q <= 1'b0;
        end
        else
        begin
            start_q <= 1'b0;
            if (awvalid && awready)
            begin
                awHave_q <= 1'b1;
                awA_q <= awaddr;
            end
            if (wvalid && wready)
            begin
                wHave_q <= 1'b1;
                wD_q <= wdata;
            end
            if (awHave_q && wHave_q)
            begin
                awHave_q <= 1'b0;
                wHave_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= 2'b00;
                if (awA_q == acsi_pkg::ADDR_CTRL && wstrb[0])
                begin
                    start_q <= wD_q[0] && !active_q;
                    devClk_q <= wD_q[1];
                end
                else if (awA_q == acsi_pkg::ADDR_CFG)
                    cfg_q <= wD_q[acsi_pkg::CFG_W-1:0];
                else if (awA_q != acsi_pkg::ADDR_CTRL)
                    bresp <= 2'b10;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= 2'b00;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rresp <= 2'b00;
            unique case (araddr)
                acsi_pkg::ADDR_CTRL:   rdata <= {30'h0, devClk_q, 1'b0};
                acsi_pkg::ADDR_STAT:   rdata <= {29'h0, link.sdoLine, link.busy, active_q};
                acsi_pkg::ADDR_RESULT: rdata <= result_q;
                acsi_pkg::ADDR_CFG:    rdata <= {16'h0, cfg_q};
                default:
                begin
                    rdata <= 32'h0;
                    rresp <= 2'b10;
                end
            endcase
        end
        else if (rvalid && rready)
            rvalid <= 1'b0;
    end

    // Frame runs after busy falls; host clock idles low.
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            active_q <= 1'b0;
            cnt_q <= 6'd0;
            sck_q <= 1'b0;
            div_q <= 4'h0;
            rx_q <= 32'h0;
            result_q <= 32'h0;
            tx_q <= '0;
            sckPrev_q <= 1'b0;
            busyPrev_q <= 1'b1;
        end
        else
        begin
            sckPrev_q <= link.sck;
            busyPrev_q <= link.busy;
            if (start_q)
            begin
                active_q <= 1'b1;
                cnt_q <= 6'd0;
                tx_q <= cfg_q;
                div_q <= 4'h0;
                sck_q <= 1'b0;
            end
            else if (active_q)
            begin
                if (!devClk_q && !link.busy)
                begin
                    div_q <= div_q + 4'h1;
                    if (div_q == 4'(acsi_pkg::SCK_HALF - 1))
                    begin
                        div_q <= 4'h0;
                        sck_q <= !sck_q;
                    end
                end
                if (rise)
                begin
                    rx_q <= {rx_q[30:0], link.sdoLine};
                    cnt_q <= cnt_q + 6'd1;
                end
                if (fall)
                    tx_q <= {tx_q[acsi_pkg::CFG_W-2:0], 1'b0};
                if (fall && cnt_q == 6'd32)
                begin
                    active_q <= 1'b0;
                    result_q <= rx_q;
                    sck_q <= 1'b0;
                end
                if (devClk_q && link.busy && !busyPrev_q)
                begin
                    active_q <= 1'b0;
                    result_q <= rx_q;
                end
            end
        end
    end

    assign link.csN = !active_q;
    assign link.sdi = tx_q[acsi_pkg::CFG_W-1];
    assign link.sckHost = sck_q;
    assign link.sckHostOeN = devClk_q || !active_q;
    assign link.clockSourceSelectN = devClk_q;
endmodule
`default_nettype wire

// ### rtl/acsi_link_if.sv
// Serial link between the converter and its host controller.
`timescale 1ns/100ps
`default_nettype none
interface acsi_link_if;
    logic csN;
    logic sdi;
    logic sdo;
    logic sdoOeN;
    logic sckHost;
    logic sckHostOeN;
    logic sckDev;
    logic sckDevOeN;
    logic busy;
    logic clockSourceSelectN;
    wire sck = !sckDevOeN ? sckDev : (!sckHostOeN ? sckHost : 1'b0);
    wire sdoLine = !sdoOeN ? sdo : 1'b1;
    modport device (input csN, sdi, sck, clockSourceSelectN,
                    output sdo, sdoOeN, sckDev, sckDevOeN, busy);
    modport host (input sdoLine, busy, sck,
                  output csN, sdi, sckHost, sckHostOeN, clockSourceSelectN);
endinterface
`default_nettype wire

// ### rtl/acsi_pkg.sv
// Shared constants and types for the converter cycle serial interface.
package acsi_pkg;
    localparam int FRAME_BITS = 32;
    localparam int DATA_W = 24;
    localparam int SUB_W = 5;
    localparam int CFG_W = 16;
    localparam int CFG_ENABLE_POS = 15;
    localparam int CFG_TWOX_POS = 14;
    localparam int CFG_OSR_POS = 10;
    localparam int CFG_OSR_W = 4;
    localparam int CFG_CH_POS = 6;
    localparam int CFG_CH_W = 4;
    localparam logic [CFG_OSR_W-1:0] OSR_CODE_RESET = 4'h1;
    localparam logic [CFG_CH_W-1:0] CH_CODE_RESET = 4'h0;
    localparam logic TWOX_RESET = 1'b0;
    localparam int OSR_RESET = 256;
    localparam int CONV_K = 40;
    localparam int CONV_OFS = 170;
    localparam int INT_OSC_KHZ = 9000;
    localparam int CONV_CLK_DIV = 14;
    localparam int SCK_HALF = 5;
    localparam int BYTE_W = 8;
    typedef enum logic [1:0] {ST_CONV, ST_SLEEP, ST_XFER} acsi_state_t;
    localparam logic [BYTE_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [BYTE_W-1:0] ADDR_STAT = 8'h04;
    localparam logic [BYTE_W-1:0] ADDR_RESULT = 8'h08;
    localparam logic [BYTE_W-1:0] ADDR_CFG = 8'h0C;
endpackage
